/* xdl_exec.sv */
// Execute stage for direction-load, xor-literal and xor-file
`timescale 1ns/1ps
`default_nettype none
module xdl_exec (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Instruction from fetch, with operand read from the file
  input  wire logic        instr_valid_i,
  input  wire logic [11:0] instr_i,
  input  wire logic [7:0]  file_data_i,
  // File register write-back
  output logic             file_we_o,
  output logic [4:0]       file_waddr_o,
  output logic [7:0]       file_wdata_o,
  // Core state
  output logic [7:0]       acc_o,
  output logic             zero_o,
  output logic [7:0]       dir_a_o,
  output logic [7:0]       dir_b_o
);
  //===================================================================
  // Registers
  logic [7:0] acc_ff;       // Accumulator
  logic       zero_ff;      // Zero flag
  logic [7:0] dir_a_ff;     // Direction register, selector 6
  logic [7:0] dir_b_ff;     // Direction register, selector 7
  logic       we_ff;        // Write-back strobe, one cycle
  logic [4:0] waddr_ff;     // Write-back address
  logic [7:0] wdata_ff;     // Write-back data

  //===================================================================
  // Decode
  wire logic       is_lit;     // Xor-literal
  wire logic       is_file;    // Xor-file
  wire logic       is_dir_a;   // Direction-load, selector 6
  wire logic       is_dir_b;   // Direction-load, selector 7
  wire logic       dest_file;  // Xor-file destination bit
  wire logic [7:0] operand;    // Second xor operand
  wire logic [7:0] xor_res;    // Xor result
  wire logic       xor_zero;   // Result is zero
  wire logic [7:0] lit_val;    // Literal field of the word
  wire logic [4:0] file_addr;  // File address field of the word

  //===================================================================
  // Direction-load match for one selector; shared by both registers
  function automatic logic dir_hit(input logic [11:0] word,
                                   input logic [2:0]  sel);
    dir_hit = (word[11:xdl_pkg::DIR_ZERO_POS] == xdl_pkg::OP_DIR) &&
              (word[2:0] == sel);
  endfunction : dir_hit

  assign is_lit  = instr_valid_i &&
                   (instr_i[11:xdl_pkg::LIT_HI_POS] == xdl_pkg::OP_LIT);
  assign is_file = instr_valid_i &&
                   (instr_i[11:xdl_pkg::FILE_OP_POS] == xdl_pkg::OP_FILE);
  // Other selectors are not direction registers and do nothing
  assign is_dir_a = instr_valid_i &&
                    dir_hit(instr_i, xdl_pkg::DIR_SEL_A);
  assign is_dir_b = instr_valid_i &&
                    dir_hit(instr_i, xdl_pkg::DIR_SEL_B);
  assign dest_file = instr_i[xdl_pkg::DEST_POS];
  assign lit_val   = instr_i[7:0];
  assign file_addr = instr_i[4:0];
  // Literal sits in the low byte, file data comes from the read port
  assign operand = is_lit ? lit_val : file_data_i;

  //===================================================================
  // Shared xor datapath
  xdl_xor_unit u_xor (
    .op_a_i (acc_ff),
    .op_b_i (operand),
    .res_o  (xor_res),
    .zero_o (xor_zero)
  );

  //===================================================================
  // Next values
  wire logic [7:0] nxt_acc;
  wire logic       nxt_zero;
  wire logic [7:0] nxt_dir_a;
  wire logic [7:0] nxt_dir_b;
  wire logic       nxt_we;

  // Accumulator takes the result on xor-literal and on xor-file with destination 0, else holds
  assign nxt_acc  = (is_lit || (is_file && !dest_file)) ?
                    xor_res : acc_ff;
  // Only the two xor forms touch the flag; direction-load keeps it
  assign nxt_zero = (is_lit || is_file) ? xor_zero : zero_ff;
  assign nxt_dir_a = is_dir_a ? acc_ff : dir_a_ff;
  assign nxt_dir_b = is_dir_b ? acc_ff : dir_b_ff;
  assign nxt_we    = is_file && dest_file;

  //===================================================================
  // Core state, one update per instruction cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc_ff   <= xdl_pkg::ACC_RST;
      zero_ff  <= xdl_pkg::ZERO_RST;
      dir_a_ff <= xdl_pkg::DIR_RST;
      dir_b_ff <= xdl_pkg::DIR_RST;
    end else begin
      acc_ff   <= nxt_acc;
      zero_ff  <= nxt_zero;
      dir_a_ff <= nxt_dir_a;
      dir_b_ff <= nxt_dir_b;
    end
  end

  //===================================================================
  // Write-back strobe; address and data held between writes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      we_ff    <= 1'b0;
      waddr_ff <= 5'h00;
      wdata_ff <= 8'h00;
    end else begin
      we_ff <= nxt_we;
      if (nxt_we) begin
        waddr_ff <= file_addr;
        wdata_ff <= xor_res;
      end
    end
  end

  //===================================================================
  // Outputs straight from flops
  assign acc_o        = acc_ff;
  assign zero_o       = zero_ff;
  assign dir_a_o      = dir_a_ff;
  assign dir_b_o      = dir_b_ff;
  assign file_we_o    = we_ff;
  assign file_waddr_o = waddr_ff;
  assign file_wdata_o = wdata_ff;

  //===================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_file_wr;
    file_we_o && (file_wdata_o == ($past(acc_o) ^ $past(file_data_i))) &&
    (file_waddr_o == $past(file_addr));
  endsequence

  property p_dir_load;
    is_dir_a |=> (dir_a_o == $past(acc_o)) && $stable(zero_o) &&
                 $stable(dir_b_o);
  endproperty
  a_dir_load: assert property (p_dir_load)
    else $error("direction register 6 not loaded from accumulator");

  property p_dir_b_load;
    is_dir_b |=> (dir_b_o == $past(acc_o)) && $stable(acc_o);
  endproperty
  a_dir_b_load: assert property (p_dir_b_load)
    else $error("direction register 7 not loaded from accumulator");

  property p_lit;
    is_lit |=> acc_o == ($past(acc_o) ^ $past(lit_val));
  endproperty
  a_lit: assert property (p_lit)
    else $error("xor literal result wrong");

  property p_lit_dest;
    is_lit |=> !file_we_o;
  endproperty
  a_lit_dest: assert property (p_lit_dest)
    else $error("xor literal wrote the file");

  property p_file_acc;
    is_file && !dest_file |=>
      (acc_o == ($past(acc_o) ^ $past(file_data_i))) && !file_we_o;
  endproperty
  a_file_acc: assert property (p_file_acc)
    else $error("xor file to accumulator wrong");

  property p_file_wr;
    is_file && dest_file |=> s_file_wr ##0 $stable(acc_o);
  endproperty
  a_file_wr: assert property (p_file_wr)
    else $error("xor file write-back wrong");

  property p_we_cause;
    file_we_o |-> $past(is_file) && $past(dest_file);
  endproperty
  a_we_cause: assert property (p_we_cause)
    else $error("file write without xor file instruction");

  property p_zero;
    (is_lit || is_file) |=> zero_o == ($past(xor_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag does not match xor result");

  property p_idle;
    !instr_valid_i |=> $stable(acc_o) && $stable(zero_o) && !file_we_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("state changed without an instruction");

  // Words that decode to nothing leave every piece of state alone
  property p_refused;
    instr_valid_i && !is_lit && !is_file && !is_dir_a && !is_dir_b |=>
      $stable(acc_o) && $stable(zero_o) && $stable(dir_a_o) &&
      $stable(dir_b_o) && !file_we_o;
  endproperty
  a_refused: assert property (p_refused)
    else $error("unrecognised word changed core state");

  // Direction registers move only on their own direction-load
  property p_dir_hold;
    !is_dir_a && !is_dir_b |=> $stable(dir_a_o) && $stable(dir_b_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction register changed without a load");

  // Address and data hold between writes so the file sees no glitch
  property p_wr_hold;
    !file_we_o |-> $stable(file_waddr_o) && $stable(file_wdata_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write address or data moved without a write");
endmodule : xdl_exec
`default_nettype wire

/* xdl_pkg.sv */
// Constants for the xor and direction-load execute block
//=====================================================================
// Function
// - Direction-load copies accumulator to direction 6/7, flags kept
// - Xor-literal: accumulator xor low eight instruction bits
// - Xor-literal result replaces the accumulator
// - Xor-file: accumulator xor addressed file register 0..31
// - Destination 0: result to accumulator, file untouched
// - Destination 1: result to file, accumulator untouched
//=====================================================================
`default_nettype none
package xdl_pkg;
  //===================================================================
  // Widths
  localparam int unsigned DATA_W  = 8;   // Data path width
  localparam int unsigned INSTR_W = 12;  // Instruction word width
  localparam int unsigned FADDR_W = 5;   // File address width

  //===================================================================
  // Field positions
  localparam int unsigned LIT_HI_POS   = 8;  // Xor-literal opcode low bit
  localparam int unsigned FILE_OP_POS  = 6;  // Xor-file opcode low bit
  localparam int unsigned DEST_POS     = 5;  // Destination select bit
  localparam int unsigned DIR_ZERO_POS = 3;  // Direction-load zero field

  //===================================================================
  // Opcodes
  localparam logic [3:0] OP_LIT  = 4'hF;         // Upper nibble 1111
  localparam logic [5:0] OP_FILE = 6'h06;        // 0001 10
  localparam logic [8:0] OP_DIR  = 9'h000;       // 0000 0000 0
  localparam logic [2:0] DIR_SEL_A = 3'h6;       // First direction reg
  localparam logic [2:0] DIR_SEL_B = 3'h7;       // Second direction reg

  //===================================================================
  // Reset values
  localparam logic [7:0] ACC_RST  = 8'h00;       // Accumulator
  localparam logic [7:0] DIR_RST  = 8'hFF;       // All pins as inputs
  localparam logic       ZERO_RST = 1'b0;        // Zero flag
endpackage : xdl_pkg
`default_nettype wire

/* xdl_xor_unit.sv */
// Exclusive-OR datapath with zero detect
`timescale 1ns/1ps
`default_nettype none
module xdl_xor_unit (
  // Operands
  input  wire logic [7:0] op_a_i,
  input  wire logic [7:0] op_b_i,
  // Result
  output logic      [7:0] res_o,
  output logic            zero_o
);
  //===================================================================
  // Pure combinational; the caller registers the outputs
  assign res_o  = op_a_i ^ op_b_i;
  assign zero_o = (res_o == 8'h00);
endmodule : xdl_xor_unit
`default_nettype wire

/* xor_and_direction_load_exec_tb.sv */
// Self-checking testbench for the xor and direction-load execute block
`timescale 1ns/1ps
`default_nettype none
module xor_and_direction_load_exec_tb;
  //===================================================================
  // Signals
  logic        clk_sys_i     = 1'b0;   // Core clock, 8 ns period
  logic        rst_i         = 1'b1;   // Async reset, held at start
  logic        instr_valid_i = 1'b0;   // Instruction strobe
  logic [11:0] instr_i       = 12'h000; // Instruction word
  logic [7:0]  file_data_i   = 8'h00;  // Operand from the file
  logic        file_we_o;              // File write pulse
  logic [4:0]  file_waddr_o;           // File write address
  logic [7:0]  file_wdata_o;           // File write data
  logic [7:0]  acc_o;                  // Accumulator
  logic        zero_o;                 // Zero flag
  logic [7:0]  dir_a_o;                // Direction register 6
  logic [7:0]  dir_b_o;                // Direction register 7
  int          bad_count   = 0;        // Mismatches seen
  int          check_count = 0;        // Comparisons made

  //===================================================================
  // Clock and device under test
  always #4 clk_sys_i = ~clk_sys_i;

  xdl_exec dut (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .file_data_i   (file_data_i),
    .file_we_o     (file_we_o),
    .file_waddr_o  (file_waddr_o),
    .file_wdata_o  (file_wdata_o),
    .acc_o         (acc_o),
    .zero_o        (zero_o),
    .dir_a_o       (dir_a_o),
    .dir_b_o       (dir_b_o)
  );

  //===================================================================
  // Shared tasks
  // Compare one value; four-state so an unknown never matches
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One idle edge with the old word still on the bus, then the new word
  // 1 ns after an edge; outputs settled on return. The idle edge keeps
  // the strobe from dropping and rising in one time step.
  task automatic exec(input logic [11:0] ins, input logic [7:0] fd);
    @(posedge clk_sys_i);
    #1;
    instr_valid_i = 1'b1;
    instr_i       = ins;
    file_data_i   = fd;
    @(posedge clk_sys_i);
    #1;
    instr_valid_i = 1'b0;
    file_data_i   = ~fd;  // Stale operand must not be reused
  endtask : exec

  // Verdict and end of run, shared with the watchdog
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  //===================================================================
  // Scenarios
  // Literal xor three times: nonzero, zero, then nonzero result
  task automatic t_lit();
    exec(12'hFB5, 8'h00);
    chk(acc_o, 12'h0B5);
    chk(zero_o, 12'h000);
    exec(12'hFB5, 8'hFF);
    chk(acc_o, 12'h000);
    chk(zero_o, 12'h001);
    exec(12'hF5A, 8'h00);
    chk(acc_o, 12'h05A);
  endtask : t_lit

  // File xor into the accumulator, top address and low address
  task automatic t_file_acc();
    exec(12'h19F, 8'h5A);
    chk(acc_o, 12'h000);
    chk(zero_o, 12'h001);
    chk(file_we_o, 12'h000);
    exec(12'h180, 8'h66);
    chk(acc_o, 12'h066);
    chk(zero_o, 12'h000);
  endtask : t_file_acc

  // File xor written back to the file, accumulator kept
  task automatic t_file_wr();
    exec(12'h1B1, 8'h66);
    chk(file_we_o, 12'h001);
    chk(file_waddr_o, 12'h011);
    chk(file_wdata_o, 12'h000);
    chk(zero_o, 12'h001);
    chk(acc_o, 12'h066);
    exec(12'h1BE, 8'h0F);
    chk(file_waddr_o, 12'h01E);
    chk(file_wdata_o, 12'h069);
    chk(zero_o, 12'h000);
    @(posedge clk_sys_i);
    #1;
    chk(file_we_o, 12'h000);
  endtask : t_file_wr

  // Direction loads on both selectors, flags kept, others ignored
  task automatic t_dir();
    exec(12'h006, 8'h00);
    chk(dir_a_o, 12'h066);
    chk(dir_b_o, 12'h0FF);
    exec(12'hF66, 8'h00);
    exec(12'h007, 8'h5A);
    chk(dir_b_o, 12'h000);
    chk(zero_o, 12'h001);
    exec(12'hF81, 8'h00);
    exec(12'h005, 8'h00);
    exec(12'h000, 8'h00);
    chk(dir_a_o, 12'h066);
    chk(dir_b_o, 12'h000);
    chk(acc_o, 12'h081);
    exec(12'h006, 8'h81);
    chk(dir_a_o, 12'h081);
    chk(zero_o, 12'h000);
  endtask : t_dir

  //===================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk({acc_o, 3'h0, zero_o}, 12'h000);
    chk({dir_a_o, dir_b_o[3:0]}, 12'hFFF);
    chk({file_we_o, file_waddr_o[2:0], file_wdata_o}, 12'h000);
    rst_i = 1'b0;
    t_lit();
    t_file_acc();
    t_file_wr();
    t_dir();
    finish_test();
  end

  // Watchdog: the sequence needs well under 100 cycles
  initial begin
    #5000;
    bad_count++;
    finish_test();
  end
endmodule : xor_and_direction_load_exec_tb
`default_nettype wire
